// *** logic/dsg_sweep_top.sv ***
// How it works
// - Excitation comes from a 27-bit phase accumulator synthesizer.
// - Accumulator input starts from start word at bytes 0x82 to 0x84.
// - Top three bits of the 27-bit start value are forced zero.
// - Host writes a 24-bit step word held in its own register.
// - Step word of one code gives sub-0.1 Hz frequency steps.
// - A sweep is defined by start word, step word and point count.
// - Synthesizer clock is derived from the external master clock.
// - Two control bits pick one of four excitation ranges.
// - Point count is 9 bits at bytes 0x88 and 0x89, at most 511.
// - Output frequency is code times mclk over 16 over two to the 27.
// - Point done and sweep done flags; sweep done blocks increments.
`timescale 1ns/1ps
`default_nettype none
module dsg_sweep_top #(
  parameter int PHASE_W = dsg_pkg::PHASE_W,
  parameter int WORD_W  = dsg_pkg::WORD_W,
  parameter int COUNT_W = dsg_pkg::COUNT_W
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Register write port from the serial slave
  input  wire logic         regWrite,
  input  wire logic [7:0]   regAddr,
  input  wire logic [7:0]   regWrData,
  // Register read port
  input  wire logic [7:0]   regRdAddr,
  output logic [7:0]        regRdData,
  // Measurement engine
  input  wire logic         pointMeasured,
  // Synthesizer outputs
  output logic [26:0]       excitationPhase,
  output logic [1:0]        excitationRange,
  output logic              excitationActive,
  output logic [26:0]       currentFreqWord
);
  dsg_phase_if phaseBus ();

  logic [WORD_W-1:0]    sweepStartFrequencyWord;
  logic [WORD_W-1:0]    sweepFrequencyStepWord;
  logic [COUNT_W-1:0]   pointCount;
  logic [COUNT_W-1:0]   stepsTaken;
  logic [PHASE_W-1:0]   freqWord;
  logic                 active;
  logic [1:0]           rangeSel;
  logic                 pointDoneFlag;
  logic                 sweepDoneFlag;
  logic [3:0]           divCount;
  dsg_pkg::dsg_state_t  state;
  logic [7:0]           rdData;

  logic [WORD_W-1:0]    next_sweepStartFrequencyWord;
  logic [WORD_W-1:0]    next_sweepFrequencyStepWord;
  logic [COUNT_W-1:0]   next_pointCount;
  logic [COUNT_W-1:0]   next_stepsTaken;
  logic [PHASE_W-1:0]   next_freqWord;
  logic                 next_active;
  logic [1:0]           next_rangeSel;
  logic                 next_pointDoneFlag;
  logic                 next_sweepDoneFlag;
  logic [3:0]           next_divCount;
  dsg_pkg::dsg_state_t  next_state;
  logic [7:0]           next_rdData;

  logic [3:0]           cmd;
  logic                 cmdValid;

  // Zero-extend a 24-bit word to the accumulator width
  function automatic logic [26:0] widen(input logic [23:0] w);
    widen = {3'b000, w};
  endfunction : widen

  // Byte lane update for multi-byte registers
  function automatic logic [23:0] put_byte(input logic [23:0] w, input logic [1:0] lane, input logic [7:0] b);
    logic [23:0] r;
    r = w;
    case (lane)
      2'h2: r[23:16] = b;
      2'h1: r[15:8] = b;
      default: r[7:0] = b;
    endcase
    put_byte = r;
  endfunction : put_byte

  assign cmdValid = regWrite && (regAddr == dsg_pkg::ADDR_CONTROL_HI);
  assign cmd      = regWrData[dsg_pkg::CMD_LSB +: 4];

  // Register writes and sweep sequencing
  always_comb begin
    next_sweepStartFrequencyWord = sweepStartFrequencyWord;
    next_sweepFrequencyStepWord  = sweepFrequencyStepWord;
    next_pointCount              = pointCount;
    next_stepsTaken              = stepsTaken;
    next_freqWord                = freqWord;
    next_rangeSel                = rangeSel;
    next_pointDoneFlag           = pointDoneFlag;
    next_sweepDoneFlag           = sweepDoneFlag;
    next_state                   = state;
    if (regWrite) begin
      case (regAddr)
        dsg_pkg::ADDR_START_HI:  next_sweepStartFrequencyWord = put_byte(sweepStartFrequencyWord, 2'h2, regWrData);
        dsg_pkg::ADDR_START_MID: next_sweepStartFrequencyWord = put_byte(sweepStartFrequencyWord, 2'h1, regWrData);
        dsg_pkg::ADDR_START_LO:  next_sweepStartFrequencyWord = put_byte(sweepStartFrequencyWord, 2'h0, regWrData);
        dsg_pkg::ADDR_STEP_HI:   next_sweepFrequencyStepWord = put_byte(sweepFrequencyStepWord, 2'h2, regWrData);
        dsg_pkg::ADDR_STEP_MID:  next_sweepFrequencyStepWord = put_byte(sweepFrequencyStepWord, 2'h1, regWrData);
        dsg_pkg::ADDR_STEP_LO:   next_sweepFrequencyStepWord = put_byte(sweepFrequencyStepWord, 2'h0, regWrData);
        dsg_pkg::ADDR_POINTS_HI: next_pointCount = {regWrData[0], pointCount[7:0]};
        dsg_pkg::ADDR_POINTS_LO: next_pointCount = {pointCount[8], regWrData};
        dsg_pkg::ADDR_CONTROL_HI: next_rangeSel = regWrData[dsg_pkg::RANGE_LSB +: 2];
        default: begin
        end
      endcase
    end
    // Commands from the control byte; flag sets further down win over these clears
    if (cmdValid) begin
      case (cmd)
        dsg_pkg::CMD_STANDBY: begin
          next_state         = dsg_pkg::ST_STANDBY;
          next_pointDoneFlag = 1'b0;
          next_sweepDoneFlag = 1'b0;
        end
        dsg_pkg::CMD_INIT: begin
          next_state    = dsg_pkg::ST_INIT;
          next_freqWord = widen(sweepStartFrequencyWord);
          next_stepsTaken = dsg_pkg::RESET_COUNT;
        end
        dsg_pkg::CMD_SWEEP: begin
          next_state         = dsg_pkg::ST_SWEEP;
          next_freqWord      = widen(sweepStartFrequencyWord);
          next_stepsTaken    = dsg_pkg::RESET_COUNT;
          next_pointDoneFlag = 1'b0;
          next_sweepDoneFlag = 1'b0;
        end
        dsg_pkg::CMD_INCREMENT: begin
          // Done sweep ignores increments
          if (state == dsg_pkg::ST_SWEEP && !sweepDoneFlag) begin
            next_freqWord      = 27'(freqWord + widen(sweepFrequencyStepWord));
            next_stepsTaken    = 9'(stepsTaken + 9'h001);
            next_pointDoneFlag = 1'b0;
          end
        end
        dsg_pkg::CMD_REPEAT: begin
          if (state == dsg_pkg::ST_SWEEP) begin
            next_pointDoneFlag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (pointMeasured && state == dsg_pkg::ST_SWEEP) begin
      next_pointDoneFlag = 1'b1;
      if (stepsTaken >= pointCount) begin
        next_sweepDoneFlag = 1'b1;
        // A standby or init command in the same cycle keeps its target state; a sweep command does not
        if (next_state == dsg_pkg::ST_SWEEP) begin
          next_state = dsg_pkg::ST_DONE;
        end
      end
    end
  end

  // Divide mclk by 16 for the synthesizer tick
  always_comb begin
    next_divCount = 4'(divCount + 4'h1);
  end

  // Registered run flag so the active output leaves a flip-flop
  always_comb begin
    next_active = (next_state != dsg_pkg::ST_STANDBY);
  end

  // Status and register readback
  always_comb begin
    next_rdData = 8'h00;
    case (regRdAddr)
      dsg_pkg::ADDR_CONTROL_HI: next_rdData = {4'h0, 1'b0, rangeSel, 1'b0};
      dsg_pkg::ADDR_START_HI:   next_rdData = sweepStartFrequencyWord[23:16];
      dsg_pkg::ADDR_START_MID:  next_rdData = sweepStartFrequencyWord[15:8];
      dsg_pkg::ADDR_START_LO:   next_rdData = sweepStartFrequencyWord[7:0];
      dsg_pkg::ADDR_STEP_HI:    next_rdData = sweepFrequencyStepWord[23:16];
      dsg_pkg::ADDR_STEP_MID:   next_rdData = sweepFrequencyStepWord[15:8];
      dsg_pkg::ADDR_STEP_LO:    next_rdData = sweepFrequencyStepWord[7:0];
      dsg_pkg::ADDR_POINTS_HI:  next_rdData = {7'h00, pointCount[8]};
      dsg_pkg::ADDR_POINTS_LO:  next_rdData = pointCount[7:0];
      dsg_pkg::ADDR_STATUS: begin
        next_rdData[dsg_pkg::POINT_DONE_BIT] = pointDoneFlag;
        next_rdData[dsg_pkg::SWEEP_DONE_BIT] = sweepDoneFlag;
      end
      default: next_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sweepStartFrequencyWord <= dsg_pkg::RESET_WORD;
      sweepFrequencyStepWord  <= dsg_pkg::RESET_WORD;
      pointCount              <= dsg_pkg::RESET_COUNT;
      stepsTaken              <= dsg_pkg::RESET_COUNT;
      freqWord                <= 27'h0000000;
      rangeSel                <= dsg_pkg::RESET_RANGE;
      pointDoneFlag           <= 1'b0;
      sweepDoneFlag           <= 1'b0;
      divCount                <= dsg_pkg::RESET_DIVCNT;
      state                   <= dsg_pkg::ST_STANDBY;
      active                  <= 1'b0;
      rdData                  <= 8'h00;
    end else begin
      sweepStartFrequencyWord <= next_sweepStartFrequencyWord;
      sweepFrequencyStepWord  <= next_sweepFrequencyStepWord;
      pointCount              <= next_pointCount;
      stepsTaken              <= next_stepsTaken;
      freqWord                <= next_freqWord;
      rangeSel                <= next_rangeSel;
      pointDoneFlag           <= next_pointDoneFlag;
      sweepDoneFlag           <= next_sweepDoneFlag;
      divCount                <= next_divCount;
      state                   <= next_state;
      active                  <= next_active;
      rdData                  <= next_rdData;
    end
  end

  // Synthesizer core hookup; standby holds phase at zero
  assign phaseBus.tick     = (divCount == 4'(dsg_pkg::MCLK_DIV - 1));
  assign phaseBus.run      = active;
  assign phaseBus.clear    = !active;
  assign phaseBus.freqWord = freqWord;

  dsg_phase_core uCore (
    .mclk   (mclk),
    .resetn (resetn),
    .bus    (phaseBus.core)
  );

  // Outputs straight from flip-flops
  assign excitationPhase  = phaseBus.phase;
  assign excitationRange  = rangeSel;
  assign excitationActive = active;
  assign currentFreqWord  = freqWord;
  assign regRdData        = rdData;
endmodule : dsg_sweep_top
`default_nettype wire

// *** pkg/dsg_pkg.sv ***
`default_nettype none
package dsg_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL_HI = 8'h80;
  localparam logic [7:0] ADDR_CONTROL_LO = 8'h81;
  localparam logic [7:0] ADDR_START_HI   = 8'h82;
  localparam logic [7:0] ADDR_START_MID  = 8'h83;
  localparam logic [7:0] ADDR_START_LO   = 8'h84;
  localparam logic [7:0] ADDR_STEP_HI    = 8'h85;
  localparam logic [7:0] ADDR_STEP_MID   = 8'h86;
  localparam logic [7:0] ADDR_STEP_LO    = 8'h87;
  localparam logic [7:0] ADDR_POINTS_HI  = 8'h88;
  localparam logic [7:0] ADDR_POINTS_LO  = 8'h89;
  localparam logic [7:0] ADDR_STATUS     = 8'h8F;
  // Widths and master clock divide ratio
  localparam int PHASE_W = 27;
  localparam int WORD_W  = 24;
  localparam int COUNT_W = 9;
  localparam int MCLK_DIV = 16;
  // Status bit positions
  localparam int POINT_DONE_BIT = 2;
  localparam int SWEEP_DONE_BIT = 3;
  // Control field positions in the high control byte
  localparam int CMD_LSB   = 4;
  localparam int RANGE_LSB = 1;
  // Commands
  localparam logic [3:0] CMD_NOP       = 4'h0;
  localparam logic [3:0] CMD_INIT      = 4'h1;
  localparam logic [3:0] CMD_SWEEP     = 4'h2;
  localparam logic [3:0] CMD_INCREMENT = 4'h3;
  localparam logic [3:0] CMD_REPEAT    = 4'h4;
  localparam logic [3:0] CMD_STANDBY   = 4'hB;
  // Reset values
  localparam logic [23:0] RESET_WORD   = 24'h000000;
  localparam logic [8:0]  RESET_COUNT  = 9'h000;
  localparam logic [1:0]  RESET_RANGE  = 2'h0;
  localparam logic [3:0]  RESET_DIVCNT = 4'h0;
  // Sweep states
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_INIT    = 2'b01,
    ST_SWEEP   = 2'b11,
    ST_DONE    = 2'b10
  } dsg_state_t;
endpackage : dsg_pkg
`default_nettype wire

// *** pkg/dsg_phase_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dsg_phase_if;
  logic        tick;
  logic        run;
  logic        clear;
  logic [26:0] freqWord;
  logic [26:0] phase;
  modport ctrl (output tick, output run, output clear, output freqWord, input phase);
  modport core (input tick, input run, input clear, input freqWord, output phase);
endinterface : dsg_phase_if
`default_nettype wire

// *** logic/dsg_phase_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsg_phase_core (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   resetn,
  // Control side
  dsg_phase_if.core   bus
);
  logic [26:0] acc;
  logic [26:0] next_acc;

  // Accumulate once per synthesizer tick
  always_comb begin
    next_acc = acc;
    if (bus.clear) begin
      next_acc = '0;
    end else if (bus.run && bus.tick) begin
      next_acc = acc + bus.freqWord;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  assign bus.phase = acc;
endmodule : dsg_phase_core
`default_nettype wire

// *** test/dsg_sweep_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsg_sweep_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Register ports
  input wire logic        regWrite,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdAddr,
  input wire logic [7:0]  regRdData,
  // Synthesizer outputs
  input wire logic [26:0] excitationPhase,
  input wire logic [1:0]  excitationRange,
  input wire logic        excitationActive,
  input wire logic [26:0] currentFreqWord
);
  logic [23:0] sStart;
  logic [23:0] sStep;
  logic        cmdWr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Control byte write seen on the port
  assign cmdWr = regWrite && regAddr == dsg_pkg::ADDR_CONTROL_HI;
  // Shadow words, rebuilt from the byte writes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sStart <= 24'h000000;
      sStep  <= 24'h000000;
    end else if (regWrite) begin
      case (regAddr)
        dsg_pkg::ADDR_START_HI:  sStart[23:16] <= regWrData;
        dsg_pkg::ADDR_START_MID: sStart[15:8] <= regWrData;
        dsg_pkg::ADDR_START_LO:  sStart[7:0] <= regWrData;
        dsg_pkg::ADDR_STEP_HI:   sStep[23:16] <= regWrData;
        dsg_pkg::ADDR_STEP_MID:  sStep[15:8] <= regWrData;
        dsg_pkg::ADDR_STEP_LO:   sStep[7:0] <= regWrData;
        default: ;
      endcase
    end
  end
  range_sel_a: assert property (cmdWr |=> excitationRange == $past(regWrData[2:1]))
    else $error("range not taken from control byte");
  sweep_load_a: assert property (cmdWr && regWrData[7:4] == dsg_pkg::CMD_SWEEP |=>
    excitationActive && currentFreqWord == {3'h0, sStart}) else $error("sweep start word wrong");
  phase_add_a: assert property (excitationActive && $past(excitationActive) && $changed(excitationPhase)
    |-> excitationPhase == $past(excitationPhase) + $past(currentFreqWord)) else $error("phase step wrong");
  tick_gap_a: assert property (excitationActive && $changed(excitationPhase) |=>
    ($stable(excitationPhase) || !excitationActive)[*8]) else $error("phase ticks too close");
  incr_add_a: assert property (cmdWr && regWrData[7:4] == dsg_pkg::CMD_INCREMENT |=>
    currentFreqWord == $past(currentFreqWord) || currentFreqWord == $past(currentFreqWord) + {3'h0, sStep})
    else $error("increment result wrong");
  rd_start_a: assert property (regRdAddr == dsg_pkg::ADDR_START_MID |=> regRdData == $past(sStart[15:8]))
    else $error("start byte readback wrong");
  rd_step_a: assert property (regRdAddr == dsg_pkg::ADDR_STEP_LO |=> regRdData == $past(sStep[7:0]))
    else $error("step byte readback wrong");
  cnt_hi_a: assert property (regRdAddr == dsg_pkg::ADDR_POINTS_HI |=> regRdData[7:1] == 7'h00)
    else $error("count high byte too wide");
endmodule : dsg_sweep_sva
bind dsg_sweep_top dsg_sweep_sva u_sva (.mclk(mclk), .resetn(resetn), .regWrite(regWrite),
  .regAddr(regAddr), .regWrData(regWrData), .regRdAddr(regRdAddr), .regRdData(regRdData),
  .excitationPhase(excitationPhase), .excitationRange(excitationRange),
  .excitationActive(excitationActive), .currentFreqWord(currentFreqWord));
`default_nettype wire

// *** test/dsg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsg_host_model (
  // Clock
  input wire logic   mclk,
  // Register write port
  output logic       regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData
);
  // Idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // One byte per strobe; lines scrambled after release so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr
  // Word sent most significant byte first
  task automatic wr24(input logic [7:0] a, input logic [23:0] w);
    wr(a, w[23:16]);
    wr(a + 8'h01, w[15:8]);
    wr(a + 8'h02, w[7:0]);
  endtask : wr24
endmodule : dsg_host_model
`default_nettype wire

// *** test/dds_frequency_sweep_generator_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dds_frequency_sweep_generator_tb_top;
  logic mclk, resetn, regWrite, pointMeasured, excitationActive;
  logic [7:0] regAddr, regWrData, regRdAddr, regRdData;
  logic [26:0] excitationPhase, currentFreqWord;
  logic [1:0] excitationRange;
  logic [31:0] rnd;
  int err_total, checked, start, step, freq, steps, pts, done, r, k;
  // Master clock from outside the block
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  dsg_sweep_top u_dut (.mclk(mclk), .resetn(resetn), .regWrite(regWrite), .regAddr(regAddr),
    .regWrData(regWrData), .regRdAddr(regRdAddr), .regRdData(regRdData), .pointMeasured(pointMeasured),
    .excitationPhase(excitationPhase), .excitationRange(excitationRange),
    .excitationActive(excitationActive), .currentFreqWord(currentFreqWord));
  dsg_host_model u_host (.mclk(mclk), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Registered readback lands one edge after the address, checked after two
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regRdAddr <= a;
    repeat (2) @(posedge mclk);
    #1 chk("regRdData", {24'h0, e}, {24'h0, regRdData & (a == dsg_pkg::ADDR_STATUS ? 8'h0C : 8'hFF)});
  endtask : rd
  task automatic cmd(input logic [3:0] c, input logic [1:0] g);
    u_host.wr(dsg_pkg::ADDR_CONTROL_HI, {c, 1'b0, g, 1'b0});
    @(posedge mclk);
    #1;
  endtask : cmd
  task automatic outs(input logic [1:0] g);
    chk("excitationActive", 1, excitationActive);
    chk("currentFreqWord", freq, currentFreqWord);
    chk("excitationRange", g, excitationRange);
  endtask : outs
  task automatic print_verdict;
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    print_verdict();
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    regRdAddr = 8'h00;
    pointMeasured = 1'b0;
    rnd = 32'hB34B;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rnd = lfsr(rnd);
    start = int'(rnd[23:0]);
    rnd = lfsr(rnd);
    step = int'(rnd[23:0]);
    u_host.wr24(dsg_pkg::ADDR_START_HI, start[23:0]);
    u_host.wr24(dsg_pkg::ADDR_STEP_HI, step[23:0]);
    u_host.wr(dsg_pkg::ADDR_POINTS_HI, 8'hFF);
    u_host.wr(dsg_pkg::ADDR_POINTS_LO, 8'hFF);
    for (k = 0; k < 3; k++) begin
      rd(8'(8'h82 + k), start[23 - 8 * k -: 8]);
      rd(8'(8'h85 + k), step[23 - 8 * k -: 8]);
    end
    rd(dsg_pkg::ADDR_POINTS_HI, 8'h01);
    rd(dsg_pkg::ADDR_POINTS_LO, 8'hFF);
    rd(8'h8C, 8'h00);
    pts = 2;
    u_host.wr(dsg_pkg::ADDR_POINTS_HI, 8'h00);
    u_host.wr(dsg_pkg::ADDR_POINTS_LO, 8'(pts));
    freq = start;
    // Every range under init, sweep and repeat
    for (r = 0; r < 4; r++) begin
      cmd(dsg_pkg::CMD_INIT, 2'(r));
      outs(2'(r));
      cmd(dsg_pkg::CMD_SWEEP, 2'(r));
      outs(2'(r));
      cmd(dsg_pkg::CMD_REPEAT, 2'(r));
      outs(2'(r));
    end
    // Accumulator from a cleared start, ticking every sixteenth clock
    cmd(dsg_pkg::CMD_STANDBY, 2'h0);
    chk("excitationPhase", 0, excitationPhase);
    cmd(dsg_pkg::CMD_SWEEP, 2'h2);
    repeat (40) @(posedge mclk);
    #1 chk("phaseTicks", 1, excitationPhase == 27'(2 * start) || excitationPhase == 27'(3 * start));
    // Points, increments and the end of the sweep
    steps = 0;
    done = 0;
    repeat (4) begin
      @(posedge mclk);
      pointMeasured <= 1'b1;
      @(posedge mclk);
      pointMeasured <= 1'b0;
      if (steps >= pts) done = 1;
      rd(dsg_pkg::ADDR_STATUS, done ? 8'h0C : 8'h04);
      cmd(dsg_pkg::CMD_INCREMENT, 2'h2);
      if (done == 0) begin
        freq = (freq + step) & 32'h07FFFFFF;
        steps++;
      end
      outs(2'h2);
    end
    cmd(dsg_pkg::CMD_STANDBY, 2'h0);
    chk("excitationActive", 0, excitationActive);
    print_verdict();
  end
endmodule : dds_frequency_sweep_generator_tb_top
`default_nettype wire
